// file: common/afr_pkg.sv
// alarm flag register bank: shared constants and carrier types
// assumes: one importer per design file, no tool-specific features
package afr_pkg;

  // ----------------------------------------------------------------
  // channel count and register offsets
  // ----------------------------------------------------------------
  localparam int NUM_CH_DEF = 8;
  localparam int NARROW_CH = 4;
  localparam logic [6:0] ADDR_OVERVIEW = 7'h10;
  localparam logic [6:0] ADDR_TRIP_LO = 7'h11;
  localparam logic [6:0] ADDR_ACT_LO = 7'h12;
  localparam logic [6:0] ADDR_TRIP_HI = 7'h13;
  localparam logic [6:0] ADDR_ACT_HI = 7'h14;

  // ----------------------------------------------------------------
  // reset and read values
  // ----------------------------------------------------------------
  localparam logic FLAG_RST = 1'b0;
  localparam logic CS_IDLE = 1'b1;
  localparam logic [7:0] ABSENT_READ = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [15:0] MASK_NONE = 16'h0000;

  // ----------------------------------------------------------------
  // serial frame timing, in link clock edges
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] DECODE_EDGE = 5'h07;
  localparam logic [4:0] LAST_OUT_EDGE = 5'h0E;
  localparam logic [2:0] TOP_BIT = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } afr_cond_t;

  typedef struct packed {
    logic [7:0] overview;
    logic [7:0] trip_lo;
    logic [7:0] act_lo;
    logic [7:0] trip_hi;
    logic [7:0] act_hi;
  } afr_flags_t;

endpackage : afr_pkg

// file: src/afr_alarm_flags.sv
// alarm flag register bank behind the serial register port
// assumes: comparator results arrive on i_clk; the host drives the
// serial port on its own clock and keeps chip select low for a
// whole frame with setup time for the frame snapshot
`timescale 1ns/100ps
`default_nettype none

module afr_alarm_flags
  import afr_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmp_valid,
  input wire afr_cond_t i_cond,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo
);

  // ----------------------------------------------------------------
  // state of both domains
  // ----------------------------------------------------------------
  localparam bit NARROW = (NUM_CH <= NARROW_CH);

  typedef struct packed {
    logic cs_prev;
    logic frame_tgl;
    logic clr_pulse;
    afr_flags_t snap;
  } afr_clk_st_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic seen_tgl;
    logic [6:0] addr;
    logic [7:0] shift;
    logic [2:0] pos;
    logic is_trip;
    logic trip_lo;
    logic sdo;
    logic [15:0] clr_mask;
  } afr_lnk_st_t;

  afr_clk_st_t clk_reg;
  afr_clk_st_t clk_next;
  afr_lnk_st_t lnk_reg;
  afr_lnk_st_t lnk_next;

  logic cs_s;
  logic ack_s;
  wire logic [15:0] trip_w;
  wire logic [15:0] act_w;
  logic [15:0] clr_w;
  wire logic [7:0] ovw;

  // ----------------------------------------------------------------
  // flag storage, word layout [15:8] low bank, [7:0] high bank
  // ----------------------------------------------------------------
  assign clr_w = clk_reg.clr_pulse ? lnk_reg.clr_mask : MASK_NONE;

  genvar c;
  generate
    for (c = 0; c < 8; c++) begin : g_ch
      localparam int IDX = ((c < 4) ? 8 : 0) + 7 - 2 * (c % 4);
      if (c < NUM_CH) begin : g_on
        // low threshold sits one bit above the high threshold
        afr_flag_cell u_low (
          .i_clk(i_clk),
          .i_rst(i_rst),
          .i_upd(i_cmp_valid),
          .i_cond(i_cond.low[c]),
          .i_clr(clr_w[IDX]),
          .o_active(act_w[IDX]),
          .o_tripped(trip_w[IDX])
        );
        afr_flag_cell u_high (
          .i_clk(i_clk),
          .i_rst(i_rst),
          .i_upd(i_cmp_valid),
          .i_cond(i_cond.high[c]),
          .i_clr(clr_w[IDX-1]),
          .o_active(act_w[IDX-1]),
          .o_tripped(trip_w[IDX-1])
        );
      end else begin : g_off
        // absent channels hold no state, so writes cannot reach them
        assign act_w[IDX] = FLAG_RST;
        assign act_w[IDX-1] = FLAG_RST;
        assign trip_w[IDX] = FLAG_RST;
        assign trip_w[IDX-1] = FLAG_RST;
      end
      assign ovw[c] = trip_w[IDX] | trip_w[IDX-1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame boundaries seen from i_clk
  // ----------------------------------------------------------------
  afr_sync2 #(
    .RST_VAL(CS_IDLE)
  ) u_cs_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(i_cs_n),
    .o_q(cs_s)
  );

  afr_sync2 #(
    .RST_VAL(FLAG_RST)
  ) u_ack_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(lnk_reg.seen_tgl),
    .o_q(ack_s)
  );

  // snapshot is frozen for the whole frame, so the link side reads a
  // stable word; the toggle announces it to the link side
  always_comb begin
    clk_next = clk_reg;
    clk_next.cs_prev = cs_s;
    clk_next.clr_pulse = 1'b0;
    if (clk_reg.cs_prev && !cs_s) begin
      clk_next.frame_tgl = ~clk_reg.frame_tgl;
      clk_next.snap.overview = NARROW ? {ABSENT_READ[7:4], ovw[3:0]} : ovw;
      clk_next.snap.trip_lo = trip_w[15:8];
      clk_next.snap.act_lo = act_w[15:8];
      clk_next.snap.trip_hi = NARROW ? ABSENT_READ : trip_w[7:0];
      clk_next.snap.act_hi = NARROW ? ABSENT_READ : act_w[7:0];
    end else if (!clk_reg.cs_prev && cs_s) begin
      // clear only if the link side really took part in this frame
      clk_next.clr_pulse = (ack_s == clk_reg.frame_tgl);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clk_reg <= '0;
      clk_reg.cs_prev <= CS_IDLE;
    end else begin
      clk_reg <= clk_next;
    end
  end

  // ----------------------------------------------------------------
  // serial side on the link clock
  // ----------------------------------------------------------------
  // frame: 7 address bits msb first, a direction bit, then 8 data bits;
  // read data leaves on o_sdo after edges 7 to 14; written data is
  // dropped because every flag register is read-only
  always_comb begin
    logic new_frame;
    logic [4:0] k;
    logic [7:0] word;
    logic [2:0] pos_n;
    new_frame = 1'b0;
    k = 5'h00;
    word = UNMAPPED_READ;
    pos_n = 3'h0;
    lnk_next = lnk_reg;
    new_frame = (clk_reg.frame_tgl != lnk_reg.seen_tgl);
    k = new_frame ? 5'h00 : lnk_reg.cnt;
    if (lnk_reg.addr == ADDR_OVERVIEW) begin
      word = clk_reg.snap.overview;
    end else if (lnk_reg.addr == ADDR_TRIP_LO) begin
      word = clk_reg.snap.trip_lo;
    end else if (lnk_reg.addr == ADDR_ACT_LO) begin
      word = clk_reg.snap.act_lo;
    end else if (lnk_reg.addr == ADDR_TRIP_HI) begin
      word = clk_reg.snap.trip_hi;
    end else if (lnk_reg.addr == ADDR_ACT_HI) begin
      word = clk_reg.snap.act_hi;
    end else begin
      word = UNMAPPED_READ;
    end
    if (new_frame) begin
      lnk_next.seen_tgl = clk_reg.frame_tgl;
      lnk_next.clr_mask = MASK_NONE;
    end
    if (new_frame || (lnk_reg.cnt < FRAME_BITS)) begin
      lnk_next.cnt = k + 5'h01;
      lnk_next.sdo = 1'b0;
      if (k < DECODE_EDGE) begin
        lnk_next.addr = {lnk_reg.addr[5:0], i_sdi};
      end else if (k == DECODE_EDGE) begin
        lnk_next.sdo = word[7];
        lnk_next.shift = {word[6:0], 1'b0};
        lnk_next.pos = TOP_BIT;
        lnk_next.trip_lo = (lnk_reg.addr == ADDR_TRIP_LO);
        lnk_next.is_trip = (lnk_reg.addr == ADDR_TRIP_LO) ||
                           ((lnk_reg.addr == ADDR_TRIP_HI) && !NARROW);
        if (lnk_next.is_trip && word[7]) begin
          lnk_next.clr_mask[{lnk_next.trip_lo, TOP_BIT}] = 1'b1;
        end
      end else if (k <= LAST_OUT_EDGE) begin
        pos_n = lnk_reg.pos - 3'h1;
        lnk_next.sdo = lnk_reg.shift[7];
        lnk_next.shift = {lnk_reg.shift[6:0], 1'b0};
        lnk_next.pos = pos_n;
        // a bit never shifted out keeps its latched event
        if (lnk_reg.is_trip && lnk_reg.shift[7]) begin
          lnk_next.clr_mask[{lnk_reg.trip_lo, pos_n}] = 1'b1;
        end
      end
    end
  end

  // the link clock may stand still during i_rst, so this side is cleared
  // asynchronously; release must come while the link clock is idle
  always_ff @(posedge i_sclk or posedge i_rst) begin
    if (i_rst) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  assign o_sdo = lnk_reg.sdo;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ovw_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s)
      |=> clk_reg.snap.overview[0] == $past(trip_w[15] | trip_w[14]))
    else $error("overview bit 0 is not the OR of channel 0 trips");

  a_low_layout: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cmp_valid && i_cond.low[0]) |=> trip_w[15] ##1 (trip_w[15] || $past(clr_w[15])))
    else $error("channel 0 low trip not at bit 7 of low bank");

  a_act_layout: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cmp_valid |=> act_w[14] == $past(i_cond.high[0]))
    else $error("channel 0 high active not at bit 6 of low bank");

  a_high_layout: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cmp_valid && i_cond.high[7] && !NARROW) |=> trip_w[0])
    else $error("channel 7 high trip not at bit 0 of high bank");

  a_act_high: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cmp_valid && !NARROW) |=> act_w[1] == $past(i_cond.low[7]))
    else $error("channel 7 low active not at bit 1 of high bank");

  a_rst_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> (trip_w == MASK_NONE) && (act_w == MASK_NONE))
    else $error("flags not zero after reset");

  a_absent_ones: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    (NARROW && (lnk_reg.cnt == DECODE_EDGE) && (clk_reg.frame_tgl == lnk_reg.seen_tgl)
      && (lnk_reg.addr == ADDR_ACT_HI)) |=> o_sdo [*8])
    else $error("absent register did not read as all ones");

  a_snap_trip_lo: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s)
      |=> clk_reg.snap.trip_lo == $past(trip_w[15:8]))
    else $error("low bank tripped snapshot differs from the flags");

  a_snap_act_lo: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s)
      |=> clk_reg.snap.act_lo == $past(act_w[15:8]))
    else $error("low bank active snapshot differs from the flags");

  a_snap_trip_hi: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && !NARROW)
      |=> clk_reg.snap.trip_hi == $past(trip_w[7:0]))
    else $error("high bank tripped snapshot differs from the flags");

  a_snap_act_hi: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && !NARROW)
      |=> clk_reg.snap.act_hi == $past(act_w[7:0]))
    else $error("high bank active snapshot differs from the flags");

  a_absent_trip_hi: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && NARROW)
      |=> clk_reg.snap.trip_hi == ABSENT_READ)
    else $error("absent tripped bank not all ones");

  a_absent_act_hi: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && NARROW)
      |=> clk_reg.snap.act_hi == ABSENT_READ)
    else $error("absent active bank not all ones");

  a_ovw_upper: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && !NARROW)
      |=> clk_reg.snap.overview[7] == ($past(trip_w[1]) | $past(trip_w[0])))
    else $error("overview bit 7 is not the OR of channel 7 trips");

  a_ovw_absent: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.cs_prev && !cs_s && NARROW)
      |=> clk_reg.snap.overview[7:4] == ABSENT_READ[7:4])
    else $error("absent overview bits not ones");

  a_snap_frozen: assert property (@(posedge i_clk) disable iff (i_rst)
    !(clk_reg.cs_prev && !cs_s)
      |=> $stable(clk_reg.snap))
    else $error("snapshot changed outside a frame start");

  a_clr_once: assert property (@(posedge i_clk) disable iff (i_rst)
    clk_reg.clr_pulse
      |=> !clk_reg.clr_pulse)
    else $error("read clear pulse longer than one cycle");

  a_clr_frame_end: assert property (@(posedge i_clk) disable iff (i_rst)
    clk_reg.clr_pulse
      |-> $past(cs_s) && !$past(clk_reg.cs_prev))
    else $error("read clear pulse away from a frame end");

  a_clr_narrow: assert property (@(posedge i_clk) disable iff (i_rst)
    (clk_reg.clr_pulse && NARROW)
      |-> clr_w[7:0] == MASK_NONE[7:0])
    else $error("absent channels received a clear");

  a_act_no_clear: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    ((lnk_reg.cnt == DECODE_EDGE) && (clk_reg.frame_tgl == lnk_reg.seen_tgl)
      && (lnk_reg.addr == ADDR_ACT_LO))
      |=> lnk_reg.clr_mask == MASK_NONE)
    else $error("active register read marked bits for clearing");

  a_sdo_first: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    ((lnk_reg.cnt == DECODE_EDGE) && (clk_reg.frame_tgl == lnk_reg.seen_tgl)
      && (lnk_reg.addr == ADDR_TRIP_LO))
      |=> o_sdo == clk_reg.snap.trip_lo[7])
    else $error("first read bit is not bit 7 of the low tripped bank");

  a_clr_mask_top: assert property (@(posedge i_sclk) disable iff (i_cs_n)
    ((lnk_reg.cnt == DECODE_EDGE) && (clk_reg.frame_tgl == lnk_reg.seen_tgl)
      && (lnk_reg.addr == ADDR_TRIP_LO) && clk_reg.snap.trip_lo[7])
      |=> lnk_reg.clr_mask[15])
    else $error("shifted-out tripped bit not marked for clearing");

endmodule : afr_alarm_flags
`default_nettype wire

// file: src/afr_flag_cell.sv
// one threshold: live active flag and sticky tripped flag
// assumes: i_upd marks a comparison result on i_cond, same clock
`timescale 1ns/100ps
`default_nettype none
module afr_flag_cell
  import afr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_upd,
  input wire logic i_cond,
  input wire logic i_clr,
  output logic o_active,
  output logic o_tripped
);

  typedef struct packed {
    logic active;
    logic tripped;
  } afr_cell_st_t;

  afr_cell_st_t st_reg;
  afr_cell_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (i_upd) begin
      st_next.active = i_cond;
    end
    // a new event in the clearing cycle wins over the clear
    st_next.tripped = (st_reg.tripped & ~i_clr) | (i_upd & i_cond);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= {FLAG_RST, FLAG_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_active = st_reg.active;
  assign o_tripped = st_reg.tripped;

  a_active_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    i_upd |=> o_active == $past(i_cond))
    else $error("active flag does not follow comparison");

  a_active_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_upd |=> $stable(o_active))
    else $error("active flag changed without a comparison");

  a_trip_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_upd && i_cond) ##1 (!i_clr) [*2] |-> o_tripped && $past(o_tripped))
    else $error("tripped flag not latched");

  a_trip_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_clr && !(i_upd && i_cond)) |=> !o_tripped)
    else $error("tripped flag survived its read clear");

endmodule : afr_flag_cell
`default_nettype wire

// file: src/afr_sync2.sv
// two flip-flop level synchroniser into i_clk
// assumes: input is a slow level from another domain or a pin
`timescale 1ns/100ps
`default_nettype none
module afr_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);

  typedef struct packed {
    logic meta;
    logic stable;
  } afr_sync_st_t;

  afr_sync_st_t st_reg;
  afr_sync_st_t st_next;

  // first stage is read only by the second stage
  always_comb begin
    st_next.meta = i_d;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.stable;

endmodule : afr_sync2
`default_nettype wire

// file: src/afr_sync2_unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: verif/afr_alarm_flags_tb.sv
// self-checking bench: eight- and four-channel banks, each with a host
// assumes: host frames are blocking tasks; comparator pulses on clk
`timescale 1ns/100ps
`default_nettype none
module afr_alarm_flags_tb
  import afr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic cmp_valid = 1'b0;
  afr_cond_t cond = '0;
  logic sclk, cs_n, sdi, sdo, sclk4, cs4_n, sdi4, sdo4;
  logic [7:0] d;
  afr_cond_t c;
  int n_errors = 0;
  int checks = 0;

  always #4 clk = ~clk;

  afr_alarm_flags #(.NUM_CH(8)) afr_alarm_flags_inst (.i_clk(clk), .i_rst(rst),
    .i_cmp_valid(cmp_valid), .i_cond(cond), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sdi(sdi), .o_sdo(sdo));
  // narrow variant shares the comparator side
  afr_alarm_flags #(.NUM_CH(4)) afr_alarm_flags_n4_inst (.i_clk(clk), .i_rst(rst),
    .i_cmp_valid(cmp_valid), .i_cond(cond), .i_sclk(sclk4), .i_cs_n(cs4_n),
    .i_sdi(sdi4), .o_sdo(sdo4));
  afr_host_model afr_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo));
  afr_host_model afr_host_model_n4_inst (.o_sclk(sclk4), .o_cs_n(cs4_n), .o_sdi(sdi4),
    .i_sdo(sdo4));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input string name, input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    afr_host_model_inst.xfer(addr, 1'b0, 8'h00, r);
    check(name, r, exp);
  endtask : rd_chk

  task automatic rd_chk4(input string name, input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    afr_host_model_n4_inst.xfer(addr, 1'b0, 8'h00, r);
    check(name, r, exp);
  endtask : rd_chk4

  task automatic pulse(input afr_cond_t v);
    @(negedge clk);
    cond = v;
    cmp_valid = 1'b1;
    @(negedge clk);
    cmp_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask : pulse

  // bank layout worked out independently: low then high, channel b first
  function automatic logic [7:0] bank(input afr_cond_t v, input int b);
    logic [7:0] r;
    for (int k = 0; k < 4; k++) begin
      r[7-2*k] = v.low[b+k];
      r[6-2*k] = v.high[b+k];
    end
    return r;
  endfunction : bank

  task automatic give_verdict;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // hang guard
  // ----------------------------------------------------------------
  initial begin
    #500_000;
    n_errors++;
    $display("[FAIL] run_time expected end seen hang");
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // raised after time zero so the link side sees a reset edge
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int a = 16; a <= 20; a++) begin
      rd_chk("reset_value", 7'(a), 8'h00);
    end
    rd_chk("unmapped_15", 7'h15, UNMAPPED_READ);
    rd_chk("unmapped_00", 7'h00, UNMAPPED_READ);
    // every threshold alone, so a swapped pair or channel shows
    for (int i = 0; i < 16; i++) begin
      c = afr_cond_t'(16'h0001 << i);
      pulse(c);
      rd_chk("act_lo", ADDR_ACT_LO, bank(c, 0));
      rd_chk("act_hi", ADDR_ACT_HI, bank(c, 4));
      rd_chk("overview", ADDR_OVERVIEW, c.high | c.low);
      pulse('0);
      rd_chk("act_lo_gone", ADDR_ACT_LO, 8'h00);
      rd_chk("act_hi_gone", ADDR_ACT_HI, 8'h00);
      rd_chk("trip_lo", ADDR_TRIP_LO, bank(c, 0));
      rd_chk("trip_hi", ADDR_TRIP_HI, bank(c, 4));
      rd_chk("trip_lo_clr", ADDR_TRIP_LO, 8'h00);
      rd_chk("trip_hi_clr", ADDR_TRIP_HI, 8'h00);
    end
    // persisting condition trips again after a read clear
    c = afr_cond_t'(16'h0002);
    pulse(c);
    rd_chk("trip_first", ADDR_TRIP_LO, 8'h20);
    pulse(c);
    rd_chk("trip_again", ADDR_TRIP_LO, 8'h20);
    rd_chk("overview_cleared", ADDR_OVERVIEW, 8'h00);
    // condition without a compare strobe is not taken
    @(negedge clk);
    cond = afr_cond_t'(16'hFFFF);
    repeat (6) @(negedge clk);
    rd_chk("act_no_strobe", ADDR_ACT_LO, 8'h20);
    rd_chk("trip_no_strobe", ADDR_TRIP_LO, 8'h00);
    // writes have no effect
    afr_host_model_inst.xfer(ADDR_ACT_LO, 1'b1, 8'hFF, d);
    afr_host_model_inst.xfer(ADDR_TRIP_HI, 1'b1, 8'hFF, d);
    rd_chk("act_after_wr", ADDR_ACT_LO, 8'h20);
    rd_chk("trip_after_wr", ADDR_TRIP_HI, 8'h00);
    // narrow variant: walked low channels all tripped, upper reads ones
    rd_chk4("n4_trip_lo", ADDR_TRIP_LO, 8'hFF);
    rd_chk4("n4_trip_lo_clr", ADDR_TRIP_LO, 8'h00);
    rd_chk4("n4_overview", ADDR_OVERVIEW, 8'hF0);
    afr_host_model_n4_inst.xfer(ADDR_TRIP_HI, 1'b1, 8'h00, d);
    rd_chk4("n4_trip_hi", ADDR_TRIP_HI, ABSENT_READ);
    rd_chk4("n4_act_hi", ADDR_ACT_HI, ABSENT_READ);
    // reset in mid-run drops a tripped flag
    pulse(afr_cond_t'(16'h0100));
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk("trip_after_rst", ADDR_TRIP_LO, 8'h00);
    rd_chk("act_after_rst", ADDR_ACT_LO, 8'h00);
    give_verdict();
  end
endmodule : afr_alarm_flags_tb
`default_nettype wire

// file: verif/afr_host_model.sv
// host controller model: drives the serial register port frame by frame
// assumes: serial clock stands low outside frames, 30 ns period inside
`timescale 1ns/100ps
`default_nettype none
module afr_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // one 16-edge frame: address, direction, data; read byte returned
  // ----------------------------------------------------------------
  // called after an alarm event to find the channel and threshold
  task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word = {addr, wr, wdata};
    rdata = 8'h00;
    o_cs_n = 1'b0;
    #40;
    for (int i = 0; i < 16; i++) begin
      o_sdi = word[15-i];
      #15 o_sclk = 1'b1;
      #15 o_sclk = 1'b0;
      // sampled on the falling edge, half a period after the launch
      if (i >= 7 && i <= 14) begin
        rdata[14-i] = i_sdo;
      end
    end
    o_cs_n = 1'b1;
    // released line: no stale value left for the device to rely on
    o_sdi = ~o_sdi;
    #100;
  endtask : xfer
endmodule : afr_host_model
`default_nettype wire
